// ---- logic/dcbm_fifo_map.vh ----
// Purpose: Constants for the dual-clock bus-matching FIFO port logic
// Assumes: Included by dcbm_fifo.v only
// Notes:   Depth fixed at 2048 words of 36 bits
`ifndef DCBM_FIFO_MAP_VH
`define DCBM_FIFO_MAP_VH
`define DCBM_DATA_W      36
`define DCBM_ADDR_W      11
`define DCBM_PTR_W       12
`define DCBM_DEPTH       12'h800
`define DCBM_WORD_W      18
`define DCBM_BYTE_W      9
`define DCBM_PTR_ZERO    12'h000
`define DCBM_PTR_ONE     12'h001
`define DCBM_PART_ZERO   2'h0
`define DCBM_PART_ONE    2'h1
`define DCBM_PARTS_LONG  2'h0
`define DCBM_PARTS_WORD  2'h1
`define DCBM_PARTS_BYTE  2'h3
`define DCBM_DATA_ZERO   36'h000000000
`define DCBM_PAD_ZERO    11'h000
`define DCBM_MEM_LAST    11'h7ff
`define DCBM_BYTE_MASK   36'h0000001ff
`define DCBM_WORD_MASK   36'h00003ffff
`define DCBM_FLAG_CLR    1'b0
`define DCBM_FLAG_SET    1'b1
`endif

// ---- logic/dcbm_fifo.v ----
// Purpose: Port logic of a unidirectional FIFO, 36-bit write side A, bus-matched read side B
// Assumes: Port clocks arrive as ordinary inputs, synchronous to i_mclk and slower than it
// Notes:   Mailbox, offset programming and retransmit are outside this block
`timescale 1ns/100ps
`include "dcbm_fifo_map.vh"

// What this block does
// R01: Side A has a 36-bit two-way data bus for writing words.
// R02: Side B has a 36-bit two-way data bus for reading words.
// R03: Almost-empty is low on side B clock when count is at or below offset.
// R04: Almost-full is low on side A clock when free space is at or below offset.
// R05: Endian pin high at reset selects most significant part first on side B.
// R06: Endian pin low at reset selects least significant part first on side B.
// R07: After reset the same pin selects standard (high) or fall-through (low) timing.
// R08: The controller keeps the endian/timing pin static during operation.
// R09: Bus-width pin low gives long words; high gives byte or word per size input.
// R10: The controller keeps the bus-width pin static during operation.
// R11: Side A transfers and its flags are timed to side A clock rising edges.
// R12: Side B transfers and its flags are timed to side B clock rising edges.
// R13: Side A transfers need side A chip select low at the edge.
// R14: Side A data outputs float while side A chip select is high.
// R15: Side B transfers need side B chip select low at the edge.
// R16: Side B data outputs float while side B chip select is high.
// R17: In standard timing the read flag shows empty memory.
// R18: In fall-through timing the read flag shows a valid word on side B.
// R19: Transfers on either side also need that side's enable high.
// R20: Write flag shows full in standard timing and space available in fall-through.
// R21: Each side keeps its own count from pointers carried across in gray code.
module dcbm_fifo (
    // Clock and reset
    input  wire        i_mclk,
    input  wire        i_rstn,
    // Mode straps
    input  wire        i_endian_timing_select,
    input  wire        i_bus_width_select,
    input  wire        i_byte_size_select,
    // Flag offsets
    input  wire [11:0] i_almost_empty_offset,
    input  wire [11:0] i_almost_full_offset,
    // Write side
    input  wire        i_write_side_clock,
    input  wire        i_write_side_chip_select_n,
    input  wire        i_write_side_enable,
    input  wire        i_write_side_write_sel,
    input  wire [35:0] i_write_side_data_bus,
    output wire [35:0] o_write_side_data_bus,
    output wire        o_write_side_data_bus_oe,
    output wire        o_full_or_input_ready,
    output wire        o_almost_full_flag_n,
    // Read side
    input  wire        i_read_side_clock,
    input  wire        i_read_side_chip_select_n,
    input  wire        i_read_side_enable,
    input  wire        i_read_side_read_sel,
    input  wire [35:0] i_read_side_data_bus,
    output wire [35:0] o_read_side_data_bus,
    output wire        o_read_side_data_bus_oe,
    output wire        o_empty_or_output_ready,
    output wire        o_almost_empty_flag_n
);

    function [11:0] bin2gray;
        input [11:0] b;
        begin
            bin2gray = b ^ (b >> 1);
        end
    endfunction

    function [11:0] gray2bin;
        input [11:0] g;
        integer k;
        begin
            gray2bin[11] = g[11];
            for (k = 10; k >= 0; k = k - 1) begin
                gray2bin[k] = gray2bin[k + 1] ^ g[k];
            end
        end
    endfunction

    // Pick one bus-matched part of a stored word into the low bits
    function [35:0] part_sel;
        input [35:0] w;
        input [1:0]  idx;
        input [1:0]  last;
        input        big;
        reg   [1:0]  eff;
        begin
            eff = big ? (last - idx) : idx; // R05 R06
            if (last == `DCBM_PARTS_BYTE)
                part_sel = (w >> (`DCBM_BYTE_W * eff)) & `DCBM_BYTE_MASK;
            else if (last == `DCBM_PARTS_WORD)
                part_sel = (w >> (`DCBM_WORD_W * eff)) & `DCBM_WORD_MASK;
            else
                part_sel = w;
        end
    endfunction

    // Pointer step, shared by both sides
    function [11:0] ptr_step;
        input [11:0] p;
        input        go;
        begin
            ptr_step = p + {`DCBM_PAD_ZERO, go};
        end
    endfunction

    // Count after a same-edge pop, or space after a same-edge push
    function [11:0] ptr_less;
        input [11:0] p;
        input        go;
        begin
            ptr_less = p - {`DCBM_PAD_ZERO, go};
        end
    endfunction

    reg [35:0] mem [0:`DCBM_MEM_LAST];

    reg        write_side_clock_d_reg;
    reg        read_side_clock_d_reg;
    reg        big_endian_reg;
    reg        fall_through_timing_reg;
    reg        in_reset_reg;
    // Pointers are one bit wider than the address so full and empty differ
    reg [11:0] wptr_reg;
    reg [11:0] rptr_reg;
    reg [11:0] wgray_reg;
    reg [11:0] rgray_reg;
    reg [11:0] wgray_b1_reg;
    reg [11:0] wgray_b2_reg;
    reg [11:0] rgray_a1_reg;
    reg [11:0] rgray_a2_reg;
    reg [35:0] hold_reg;
    reg        hold_valid_reg;
    reg [1:0]  part_reg;
    reg [35:0] rd_data_reg;
    reg        full_flag_reg;
    reg        af_flag_reg;
    reg        ef_flag_reg;
    reg        ae_flag_reg;

    wire       a_edge = i_write_side_clock & ~write_side_clock_d_reg;
    wire       b_edge = i_read_side_clock & ~read_side_clock_d_reg;
    wire [1:0] last_part = ~i_bus_width_select ? `DCBM_PARTS_LONG :
                           (i_byte_size_select ? `DCBM_PARTS_BYTE : `DCBM_PARTS_WORD); // R09

    // Counts seen by each side
    wire [11:0] count_a = wptr_reg - gray2bin(rgray_a2_reg); // R21
    wire [11:0] count_b = gray2bin(wgray_b2_reg) - rptr_reg; // R21
    wire        full_a  = (count_a == `DCBM_DEPTH);
    wire        empty_b = (count_b == `DCBM_PTR_ZERO);

    wire wr_go = a_edge & ~i_write_side_chip_select_n & i_write_side_enable
                 & i_write_side_write_sel & ~full_a; // R11 R13 R19
    wire rd_req = b_edge & ~i_read_side_chip_select_n & i_read_side_enable
                  & i_read_side_read_sel; // R12 R15 R19

    // Read-stage control
    reg        pop;
    reg        hold_valid_next;
    reg [1:0]  part_next;
    reg [35:0] hold_next;
    always @* begin
        pop             = 1'b0;
        hold_valid_next = hold_valid_reg;
        part_next       = part_reg;
        hold_next       = hold_reg;
        if (b_edge) begin
            if (rd_req && hold_valid_reg && part_reg != last_part) begin
                part_next = part_reg + `DCBM_PART_ONE;
            end else if (fall_through_timing_reg) begin
                if (!hold_valid_reg || rd_req) begin
                    pop             = ~empty_b; // R18
                    hold_valid_next = ~empty_b;
                    part_next       = `DCBM_PART_ZERO;
                end
            end else if (rd_req) begin
                pop             = ~empty_b;
                hold_valid_next = ~empty_b;
                part_next       = `DCBM_PART_ZERO;
            end
            if (pop)
                hold_next = mem[rptr_reg[`DCBM_ADDR_W-1:0]];
        end
    end

    // Flag and data next values, all taken from the state after this edge's transfer
    reg        full_next;
    reg        af_next;
    reg        ef_next;
    reg        ae_next;
    reg [35:0] rd_data_next;
    reg [11:0] left_b;
    always @* begin
        // Side B flags count this edge's pop
        left_b       = ptr_less(count_b, pop);
        // Side A flags count this edge's write
        full_next    = ((ptr_step(wptr_reg, wr_go) - gray2bin(rgray_a2_reg)) == `DCBM_DEPTH); // R20
        af_next      = (ptr_less(`DCBM_DEPTH - count_a, wr_go) <= i_almost_full_offset); // R04
        ae_next      = (left_b <= i_almost_empty_offset); // R03
        rd_data_next = part_sel(hold_next, part_next, last_part, big_endian_reg); // R02 R09
        // Standard empty waits until the held word is fully read out
        if (fall_through_timing_reg)
            ef_next = hold_valid_next; // R18
        else
            ef_next = ~((left_b == `DCBM_PTR_ZERO) & ((part_next == last_part) | ~hold_valid_next)); // R17
    end

    always @(posedge i_mclk) begin
        if (wr_go)
            mem[wptr_reg[`DCBM_ADDR_W-1:0]] <= i_write_side_data_bus; // R01
    end

    // Mode straps: endian follows the pin through reset, timing is taken once on release
    // The pin doubles as timing select afterwards, so endian must not be read then
    always @(posedge i_mclk) begin
        in_reset_reg <= ~i_rstn;
        if (!i_rstn)
            big_endian_reg <= i_endian_timing_select; // R05 R06
        if (in_reset_reg && i_rstn)
            fall_through_timing_reg <= ~i_endian_timing_select; // R07 R08
    end

    // Port clock samplers; a pin that is low at release gives no false edge
    // Port clocks must run at most half of i_mclk or edges are lost
    always @(posedge i_mclk) begin
        if (!i_rstn) begin
            write_side_clock_d_reg <= `DCBM_FLAG_CLR;
            read_side_clock_d_reg <= `DCBM_FLAG_CLR;
        end else begin
            write_side_clock_d_reg <= i_write_side_clock;
            read_side_clock_d_reg <= i_read_side_clock;
        end
    end

    // Side A domain: write pointer, two-stage pickup of the read pointer, write flags
    always @(posedge i_mclk) begin
        if (!i_rstn) begin
            wptr_reg      <= `DCBM_PTR_ZERO;
            wgray_reg     <= `DCBM_PTR_ZERO;
            rgray_a1_reg  <= `DCBM_PTR_ZERO;
            rgray_a2_reg  <= `DCBM_PTR_ZERO;
            full_flag_reg <= `DCBM_FLAG_SET;
            af_flag_reg   <= `DCBM_FLAG_CLR;
        end else begin
            if (a_edge) begin
                rgray_a1_reg  <= rgray_reg; // R21
                rgray_a2_reg  <= rgray_a1_reg;
                full_flag_reg <= full_next; // R11 R20
                af_flag_reg   <= af_next; // R04 R11
            end
            if (wr_go) begin
                wptr_reg  <= ptr_step(wptr_reg, wr_go);
                wgray_reg <= bin2gray(ptr_step(wptr_reg, wr_go)); // R21
            end
        end
    end

    // Side B domain: read pointer, two-stage pickup of the write pointer, output stage, read flags
    always @(posedge i_mclk) begin
        if (!i_rstn) begin
            rptr_reg       <= `DCBM_PTR_ZERO;
            rgray_reg      <= `DCBM_PTR_ZERO;
            wgray_b1_reg   <= `DCBM_PTR_ZERO;
            wgray_b2_reg   <= `DCBM_PTR_ZERO;
            hold_reg       <= `DCBM_DATA_ZERO;
            hold_valid_reg <= `DCBM_FLAG_CLR;
            part_reg       <= `DCBM_PART_ZERO;
            rd_data_reg    <= `DCBM_DATA_ZERO;
            ef_flag_reg    <= `DCBM_FLAG_CLR;
            ae_flag_reg    <= `DCBM_FLAG_SET;
        end else begin
            if (b_edge) begin
                wgray_b1_reg   <= wgray_reg; // R21
                wgray_b2_reg   <= wgray_b1_reg;
                hold_valid_reg <= hold_valid_next;
                part_reg       <= part_next;
                hold_reg       <= hold_next;
                rd_data_reg    <= rd_data_next; // R02 R12
                ef_flag_reg    <= ef_next; // R12 R17 R18
                ae_flag_reg    <= ae_next; // R03 R12
            end
            if (pop) begin
                rptr_reg  <= ptr_step(rptr_reg, pop);
                rgray_reg <= bin2gray(ptr_step(rptr_reg, pop)); // R21
            end
        end
    end

    // Side A drives only on a read cycle; no FIFO data is readable there
    assign o_write_side_data_bus    = `DCBM_DATA_ZERO;
    assign o_write_side_data_bus_oe = ~i_write_side_chip_select_n & ~i_write_side_write_sel; // R14
    assign o_read_side_data_bus     = rd_data_reg;
    assign o_read_side_data_bus_oe  = ~i_read_side_chip_select_n & i_read_side_read_sel; // R16
    // Both readings are high while a write can be taken: not full, or input ready
    // Reset loads full, so a writer holds off until the first side A edge after release
    assign o_full_or_input_ready    = ~full_flag_reg; // R20
    assign o_almost_full_flag_n     = ~af_flag_reg;
    assign o_empty_or_output_ready  = ef_flag_reg;
    assign o_almost_empty_flag_n    = ~ae_flag_reg;

endmodule

// ---- dv/dcbm_fifo_sva.sv ----
// Purpose: Port timing checks for dcbm_fifo
// Assumes: Port clocks are sampled by i_mclk
// Notes:   Flags may move only one cycle after a sampled port clock rise, read data one or two cycles after; bus enables follow the strobes
`timescale 1ns/100ps
module dcbm_fifo_sva (
    input wire        i_mclk, i_rstn,
    input wire        i_write_side_clock, i_read_side_clock,
    input wire        i_write_side_chip_select_n, i_write_side_write_sel,
    input wire        i_read_side_chip_select_n, i_read_side_read_sel,
    input wire [35:0] o_write_side_data_bus, o_read_side_data_bus,
    input wire        o_write_side_data_bus_oe, o_read_side_data_bus_oe,
    input wire        o_full_or_input_ready, o_almost_full_flag_n,
    input wire        o_empty_or_output_ready, o_almost_empty_flag_n
);
    reg a_q, b_q, a_hit, b_hit;
    // Registered so the hit lines up with the cycle the outputs become visible
    always @(posedge i_mclk) begin
        a_q   <= i_write_side_clock;
        b_q   <= i_read_side_clock;
        a_hit <= i_write_side_clock & ~a_q;
        b_hit <= i_read_side_clock & ~b_q;
    end
    default clocking dc @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    a_a_oe_ctl: assert property (o_write_side_data_bus_oe ==
        (!i_write_side_chip_select_n && !i_write_side_write_sel)) else $error("side A enable wrong");
    a_b_oe_ctl: assert property (o_read_side_data_bus_oe ==
        (!i_read_side_chip_select_n && i_read_side_read_sel)) else $error("side B enable wrong");
    a_a_data_zero: assert property (o_write_side_data_bus_oe |-> o_write_side_data_bus == 36'h0)
        else $error("side A drives data");
    a_ae_b_edge: assert property ($changed(o_almost_empty_flag_n) |-> b_hit)
        else $error("almost empty moved off edge");
    a_ef_b_edge: assert property (!b_hit |-> $stable(o_empty_or_output_ready))
        else $error("empty flag moved off edge");
    a_af_a_edge: assert property ($changed(o_almost_full_flag_n) |-> a_hit)
        else $error("almost full moved off edge");
    a_ff_a_edge: assert property (!a_hit |-> $stable(o_full_or_input_ready))
        else $error("full flag moved off edge");
    a_rd_b_edge: assert property (!b_hit [*2] |-> $stable(o_read_side_data_bus))
        else $error("read data moved off edge");
    c_full: cover property (a_hit && !o_full_or_input_ready);
    c_ready: cover property ($rose(o_empty_or_output_ready));
    c_b_read: cover property ($rose(o_read_side_data_bus_oe));
endmodule

// ---- dv/dcbm_port_host.sv ----
// Purpose: Bus-controller model for both ports of dcbm_fifo
// Assumes: Strobes change at falling edges of i_mclk
// Notes:   Released side A data shows the inverse of the last word
`timescale 1ns/100ps
module dcbm_port_host (
    // System clock
    input  wire        i_mclk,
    // Side A
    output wire        o_write_side_clock,
    output reg         o_cs_a_n,
    output reg         o_en_a,
    output reg         o_wsel,
    output reg  [35:0] o_data_a,
    // Side B
    output wire        o_read_side_clock,
    output reg         o_cs_b_n,
    output reg         o_en_b,
    output wire        o_rsel
);
    reg [3:0] c;
    // Never gated; the two rates differ so edges drift against each other
    assign o_write_side_clock = c[1];
    assign o_read_side_clock = (c % 4'h6) >= 4'h3;
    assign o_rsel = 1'b1;
    initial begin
        c = 4'h0;
        o_cs_a_n = 1'b1;
        o_en_a = 1'b0;
        o_wsel = 1'b1;
        o_data_a = 36'h0;
        o_cs_b_n = 1'b1;
        o_en_b = 1'b0;
    end
    always @(negedge i_mclk) begin
        c <= (c == 4'hb) ? 4'h0 : c + 4'h1;
    end
    // Strobes held from the port clock rise through the sampling edge
    task wr(input [35:0] d, input cs_n, input en, input sel);
        begin
            @(posedge o_write_side_clock);
            o_cs_a_n = cs_n;
            o_en_a = en;
            o_wsel = sel;
            o_data_a = d;
            @(negedge i_mclk);
            o_cs_a_n = 1'b1;
            o_en_a = 1'b0;
            o_data_a = ~d;
        end
    endtask
    task rd;
        begin
            @(posedge o_read_side_clock);
            o_cs_b_n = 1'b0;
            o_en_b = 1'b1;
            @(negedge i_mclk);
            o_cs_b_n = 1'b1;
            o_en_b = 1'b0;
        end
    endtask
endmodule

// ---- dv/dual_clock_bus_match_fifo_ports_test.sv ----
// Purpose: Self-checking bench for the dcbm_fifo port logic
// Assumes: dcbm_port_host supplies port clocks and strobes
// Notes:   One full fill of 2048 words, about 8200 cycles
`timescale 1ns/100ps
module dual_clock_bus_match_fifo_ports_test;
    reg         i_mclk, i_rstn, ets, bm, sz;
    wire        write_side_clock, csa_n, ena, wsel, read_side_clock, csb_n, read_side_enable, rsel;
    wire        a_oe, b_oe, ff, af_n, ef, ae_n;
    wire [35:0] da, a_out, b_out;
    integer     n_mismatch, n_compared, k, i;
    dcbm_port_host host (.i_mclk(i_mclk), .o_write_side_clock(write_side_clock), .o_cs_a_n(csa_n), .o_en_a(ena), .o_wsel(wsel),
        .o_data_a(da), .o_read_side_clock(read_side_clock), .o_cs_b_n(csb_n), .o_en_b(read_side_enable), .o_rsel(rsel));
    // Two-way pins resolved here; an undriven B bus shows the inverse of its last value
    dcbm_fifo dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_endian_timing_select(ets), .i_bus_width_select(bm),
        .i_byte_size_select(sz), .i_almost_empty_offset(12'h000), .i_almost_full_offset(12'h7ff),
        .i_write_side_clock(write_side_clock), .i_write_side_chip_select_n(csa_n), .i_write_side_enable(ena),
        .i_write_side_write_sel(wsel), .i_write_side_data_bus(a_oe ? a_out : da),
        .o_write_side_data_bus(a_out), .o_write_side_data_bus_oe(a_oe), .o_full_or_input_ready(ff),
        .o_almost_full_flag_n(af_n), .i_read_side_clock(read_side_clock), .i_read_side_chip_select_n(csb_n),
        .i_read_side_enable(read_side_enable), .i_read_side_read_sel(rsel), .i_read_side_data_bus(b_oe ? b_out : ~b_out),
        .o_read_side_data_bus(b_out), .o_read_side_data_bus_oe(b_oe), .o_empty_or_output_ready(ef),
        .o_almost_empty_flag_n(ae_n));
    always #50 i_mclk = ~i_mclk;
    task wrap_up;
        begin
            $display("compared %0d mismatches %0d", n_compared, n_mismatch);
            if (n_mismatch == 0 && n_compared > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    task chk(input [63:0] nm, input [35:0] exp, input [35:0] got);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("mismatch %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    function pick(input [1:0] s);
        pick = (s == 2'h0) ? ef : (s == 2'h1) ? ae_n : ff;
    endfunction
    task wt(input [1:0] s, input v);
        begin
            k = 0;
            while (pick(s) !== v && k < 300) begin
                @(negedge i_mclk);
                k = k + 1;
            end
            chk("flag", v, pick(s));
            if (k == 300)
                wrap_up;
        end
    endtask
    // Release lands where both port clocks are low and no rise comes for two cycles
    task rst(input e, input t, input b, input s);
        begin
            @(negedge i_mclk);
            i_rstn = 1'b0;
            ets = e;
            bm = b;
            sz = s;
            repeat (8) @(negedge i_mclk);
            do @(posedge i_mclk); while (host.c != 4'hb);
            @(negedge i_mclk);
            i_rstn = 1'b1;
            ets = t;
        end
    endtask
    // Fall-through with bus matching: every lane of one word in endian order
    task fall(input e, input s, input integer n, input [35:0] w);
        integer j;
        integer wd;
        begin
            rst(e, 1'b0, 1'b1, s);
            wt(2'h2, 1'b1);
            host.wr(w, 1'b0, 1'b1, 1'b1);
            wt(2'h0, 1'b1);
            wd = 36 / n;
            for (j = 0; j < n; j = j + 1) begin
                chk("lane", (w >> ((e ? n - 1 - j : j) * wd)) & ((36'h1 << wd) - 36'h1), b_out);
                host.rd;
            end
            chk("ready", 1'b0, ef);
        end
    endtask
    initial begin
        i_mclk = 1'b0;
        i_rstn = 1'b0;
        ets = 1'b1;
        bm = 1'b0;
        sz = 1'b0;
        n_mismatch = 0;
        n_compared = 0;
        rst(1'b1, 1'b1, 1'b0, 1'b0);
        wt(2'h2, 1'b1);
        chk("aempty", 1'b0, ae_n);
        chk("empty", 1'b0, ef);
        chk("afull", 1'b1, af_n);
        chk("a_oe", 1'b0, a_oe);
        chk("b_oe", 1'b0, b_oe);
        host.wr(36'h5a5a5a5a5, 1'b1, 1'b1, 1'b1);
        host.wr(36'h5a5a5a5a5, 1'b0, 1'b0, 1'b1);
        host.wr(36'h5a5a5a5a5, 1'b0, 1'b1, 1'b0);
        chk("afull", 1'b1, af_n);
        host.wr(36'h876543210, 1'b0, 1'b1, 1'b1);
        chk("afull", 1'b0, af_n);
        wt(2'h0, 1'b1);
        wt(2'h1, 1'b1);
        host.rd;
        chk("long", 36'h876543210, b_out);
        chk("empty", 1'b0, ef);
        for (i = 0; i < 2048; i = i + 1)
            host.wr(i, 1'b0, 1'b1, 1'b1);
        chk("full", 1'b0, ff);
        host.wr(36'hfffffffff, 1'b0, 1'b1, 1'b1);
        wt(2'h0, 1'b1);
        host.rd;
        chk("first", 36'h0, b_out);
        fall(1'b0, 1'b1, 4, 36'h123456789);
        fall(1'b1, 1'b0, 2, 36'h9abcdef01);
        wrap_up;
    end
endmodule
bind dcbm_fifo dcbm_fifo_sva u_sva (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_write_side_clock(i_write_side_clock),
    .i_read_side_clock(i_read_side_clock), .i_write_side_chip_select_n(i_write_side_chip_select_n),
    .i_write_side_write_sel(i_write_side_write_sel), .i_read_side_chip_select_n(i_read_side_chip_select_n),
    .i_read_side_read_sel(i_read_side_read_sel), .o_write_side_data_bus(o_write_side_data_bus),
    .o_read_side_data_bus(o_read_side_data_bus), .o_write_side_data_bus_oe(o_write_side_data_bus_oe),
    .o_read_side_data_bus_oe(o_read_side_data_bus_oe), .o_full_or_input_ready(o_full_or_input_ready),
    .o_almost_full_flag_n(o_almost_full_flag_n), .o_empty_or_output_ready(o_empty_or_output_ready),
    .o_almost_empty_flag_n(o_almost_empty_flag_n));
